// ===== ldi_target.sv
`timescale 1ns/1ps
`include "ldi_consts.svh"
module ldi_target #(
  parameter int unsigned EN_LOW_CYC = `LDI_EN_LOW_CYC
) (
  // Device clock and resets
  input  wire logic       dev_clk,
  input  wire logic       por_n,
  input  wire logic       en,
  // Serial bus
  ldi_bus_if.target       bus,
  // Register write and read side
  output logic            reg_wr,
  output logic [3:0]      reg_wr_index,
  output logic [7:0]      reg_wr_data,
  output logic            init_pulse,
  output logic            rd_strobe,
  // Status
  output logic [7:0]      command_pointer,
  output logic            bus_active,
  output logic            osc_run
);
  localparam int unsigned CW = $clog2(EN_LOW_CYC + 1);

  logic [2:0]          sync_q;
  logic                scl_s;
  logic                sda_s;
  logic                en_s;
  logic                scl_q;
  logic                sda_q;
  logic [CW-1:0]       low_cnt;
  logic                shut;
  ldi_pkg::ldi_dstate_t state;
  ldi_pkg::ldi_kind_t  kind;
  logic                dir_rd;
  logic [3:0]          bit_cnt;
  logic [7:0]          shift;
  logic [7:0]          tx;
  logic [7:0]          regs [0:`LDI_REG_COUNT-1];
  logic [7:0]          rd_byte;
  logic [3:0]          ptr_idx;
  logic                start_c;
  logic                stop_c;
  logic                rise;
  logic                fall;
  logic                byte_fall;
  logic                addr_hit;
  logic                wr_fire;
  logic                load_tx;

  function automatic logic [7:0] ldi_reg_default(input int unsigned idx);
    if (idx >= `LDI_IDX_TIME_FIRST && idx <= `LDI_IDX_TIME_LAST) begin
      return `LDI_RST_TIME;
    end else if (idx == `LDI_IDX_MAXINT) begin
      return `LDI_RST_MAXINT;
    end else if (idx == `LDI_IDX_ONESHOT) begin
      return `LDI_RST_ONESHOT;
    end
    return `LDI_RST_SELECT;
  endfunction : ldi_reg_default

  // Only the pointer nibble advances; the flag and upper bits stay as sent
  function automatic logic [7:0] ldi_next_ptr(input logic [7:0] cmd);
    logic [7:0] nxt;
    nxt = cmd;
    if (cmd[`LDI_PTR_MSB:`LDI_PTR_LSB] == `LDI_PTR_LAST) begin
      nxt[`LDI_PTR_MSB:`LDI_PTR_LSB] = 4'h0;
    end else begin
      nxt[`LDI_PTR_MSB:`LDI_PTR_LSB] = cmd[`LDI_PTR_MSB:`LDI_PTR_LSB] + 4'h1;
    end
    return nxt;
  endfunction : ldi_next_ptr

  ldi_sync #(.WIDTH(3)) u_sync (
    .clk   (dev_clk),
    .rst_n (por_n),
    .d     ({bus.scl, bus.sda, en}),
    .q     (sync_q)
  );

  assign scl_s = sync_q[2];
  assign sda_s = sync_q[1];
  assign en_s  = sync_q[0];

  assign bus.tgt_sda_o = 1'b0;

  // Short enable glitches are filtered; only a long low shuts down
  always_ff @(posedge dev_clk or negedge por_n) begin
    if (!por_n) begin
      low_cnt <= '0;
    end else if (en_s) begin
      low_cnt <= '0;
    end else if (low_cnt != CW'(EN_LOW_CYC)) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  assign shut = (low_cnt == CW'(EN_LOW_CYC));

  always_ff @(posedge dev_clk or negedge por_n) begin
    if (!por_n) begin
      osc_run <= 1'b0;
    end else begin
      osc_run <= ~shut;
    end
  end

  always_ff @(posedge dev_clk or negedge por_n) begin
    if (!por_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign start_c   = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c    = scl_s & scl_q & ~sda_q & sda_s;
  assign rise      = scl_s & ~scl_q;
  assign fall      = ~scl_s & scl_q;
  assign byte_fall = fall && (state == ldi_pkg::D_RX) && (bit_cnt == 4'h8);
  assign addr_hit  = (shift[7:1] == `LDI_DEV_ADDR);
  assign wr_fire   = byte_fall && (kind == ldi_pkg::K_DATA) && !start_c && !stop_c;
  assign ptr_idx   = command_pointer[`LDI_PTR_MSB:`LDI_PTR_LSB];
  // Write-only initialization and unmapped pointers read back as zero
  assign rd_byte   = (ptr_idx < 4'(`LDI_REG_COUNT)) ? regs[ptr_idx] : 8'h00;
  assign load_tx   = fall && !start_c && !stop_c &&
                     (((state == ldi_pkg::D_RX_ACK) && (kind == ldi_pkg::K_ADDR) && dir_rd) ||
                      (state == ldi_pkg::D_TX_ACK));

  // Protocol engine
  always_ff @(posedge dev_clk or negedge por_n) begin
    if (!por_n) begin
      state           <= ldi_pkg::D_IDLE;
      kind            <= ldi_pkg::K_ADDR;
      dir_rd          <= 1'b0;
      bit_cnt         <= 4'h0;
      shift           <= 8'h00;
      tx              <= 8'h00;
      bus.tgt_sda_oe_n <= 1'b1;
      command_pointer <= `LDI_RST_CMD;
    end else if (shut) begin
      state           <= ldi_pkg::D_IDLE;
      kind            <= ldi_pkg::K_ADDR;
      dir_rd          <= 1'b0;
      bit_cnt         <= 4'h0;
      shift           <= 8'h00;
      tx              <= 8'h00;
      bus.tgt_sda_oe_n <= 1'b1;
      command_pointer <= `LDI_RST_CMD;
    end else if (start_c) begin
      state           <= ldi_pkg::D_RX;
      kind            <= ldi_pkg::K_ADDR;
      bit_cnt         <= 4'h0;
      bus.tgt_sda_oe_n <= 1'b1;
    end else if (stop_c) begin
      // Pointer is kept as received, the engine simply waits
      state           <= ldi_pkg::D_IDLE;
      bus.tgt_sda_oe_n <= 1'b1;
    end else begin
      case (state)
        ldi_pkg::D_IDLE: begin
          bus.tgt_sda_oe_n <= 1'b1;
        end
        ldi_pkg::D_RX: begin
          if (rise && bit_cnt != 4'h8) begin
            shift   <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (byte_fall) begin
            if (kind == ldi_pkg::K_ADDR && !addr_hit) begin
              state <= ldi_pkg::D_IDLE;
            end else begin
              bus.tgt_sda_oe_n <= 1'b0;
              state <= ldi_pkg::D_RX_ACK;
              if (kind == ldi_pkg::K_ADDR) begin
                dir_rd <= shift[0];
              end
              if (kind == ldi_pkg::K_CMD) begin
                // Reserved top bits are stored as sent; a zero is expected
                command_pointer <= shift;
              end
              if (kind == ldi_pkg::K_DATA && command_pointer[`LDI_AUTOINC_BIT]) begin
                command_pointer <= ldi_next_ptr(command_pointer);
              end
            end
          end
        end
        ldi_pkg::D_RX_ACK: begin
          if (fall) begin
            bit_cnt <= 4'h0;
            if (load_tx) begin
              state           <= ldi_pkg::D_TX;
              tx              <= rd_byte;
              bus.tgt_sda_oe_n <= rd_byte[7];
              if (command_pointer[`LDI_AUTOINC_BIT]) begin
                command_pointer <= ldi_next_ptr(command_pointer);
              end
            end else begin
              bus.tgt_sda_oe_n <= 1'b1;
              state           <= ldi_pkg::D_RX;
              // Write transfers alone carry a command byte
              kind <= (kind == ldi_pkg::K_ADDR) ? ldi_pkg::K_CMD : ldi_pkg::K_DATA;
            end
          end
        end
        ldi_pkg::D_TX: begin
          if (fall) begin
            if (bit_cnt == 4'h7) begin
              bus.tgt_sda_oe_n <= 1'b1;
              state           <= ldi_pkg::D_TX_ACK;
            end else begin
              bit_cnt         <= bit_cnt + 4'h1;
              tx              <= {tx[6:0], 1'b0};
              bus.tgt_sda_oe_n <= tx[6];
            end
          end
        end
        ldi_pkg::D_TX_ACK: begin
          if (rise && sda_s) begin
            state <= ldi_pkg::D_IDLE;
          end else if (load_tx) begin
            bit_cnt         <= 4'h0;
            state           <= ldi_pkg::D_TX;
            tx              <= rd_byte;
            bus.tgt_sda_oe_n <= rd_byte[7];
            if (command_pointer[`LDI_AUTOINC_BIT]) begin
              command_pointer <= ldi_next_ptr(command_pointer);
            end
          end
        end
        default: begin
          state           <= ldi_pkg::D_IDLE;
          bus.tgt_sda_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // Register storage; pointers past the map are acknowledged but dropped
  always_ff @(posedge dev_clk or negedge por_n) begin
    if (!por_n) begin
      for (int i = 0; i < `LDI_REG_COUNT; i++) begin
        regs[i] <= ldi_reg_default(i);
      end
    end else if (shut) begin
      for (int i = 0; i < `LDI_REG_COUNT; i++) begin
        regs[i] <= ldi_reg_default(i);
      end
    end else if (wr_fire && ptr_idx < 4'(`LDI_REG_COUNT)) begin
      regs[ptr_idx] <= shift;
    end
  end

  // Write and read notifications for the LED engines
  always_ff @(posedge dev_clk or negedge por_n) begin
    if (!por_n) begin
      reg_wr       <= 1'b0;
      reg_wr_index <= 4'h0;
      reg_wr_data  <= 8'h00;
      init_pulse   <= 1'b0;
      rd_strobe    <= 1'b0;
      bus_active   <= 1'b0;
    end else begin
      reg_wr       <= wr_fire && !shut && ptr_idx < 4'(`LDI_REG_COUNT);
      init_pulse   <= wr_fire && !shut && ptr_idx == `LDI_PTR_LAST;
      rd_strobe    <= load_tx && !shut;
      bus_active   <= (state != ldi_pkg::D_IDLE) && !shut;
      if (wr_fire) begin
        reg_wr_index <= ptr_idx;
        reg_wr_data  <= shift;
      end
    end
  end
endmodule : ldi_target

// ===== ldi_consts.svh
// Summary of operation
// - Write: START, address+0, pointer, data, STOP.
// - Read: pointer write, repeated START, address+1.
// - Controller acks wanted bytes, nacks last, STOP.
// - Target answers address 1000101; LSB gives direction.
// - First write byte is command; low nibble points.
// - Command only in writes; reads use stored pointer.
// - Flag clear: all data to same register.
// - Flag set: pointer increments after each byte.
// - After initialization register, pointer wraps to zero.
// - Controller sends command bits seven to five zero; ldi_ctrl sends cmd_byte from pwdata[7:0] unmasked.
// - STOP after command keeps it as pointer.
// - Pointers 0x00 to 0x0A map eleven registers.
// - Enable low 60 us resets everything, stops oscillator.
`ifndef LDI_CONSTS_SVH
`define LDI_CONSTS_SVH

// Target address and command byte layout
`define LDI_DEV_ADDR        7'h45
`define LDI_AUTOINC_BIT     4
`define LDI_PTR_MSB         3
`define LDI_PTR_LSB         0
`define LDI_RSV_MSB         7
`define LDI_RSV_LSB         5

// Register map
`define LDI_REG_COUNT       10
`define LDI_PTR_LAST        4'ha
`define LDI_IDX_TIME_FIRST  4'h3
`define LDI_IDX_TIME_LAST   4'h7
`define LDI_IDX_MAXINT      4'h8
`define LDI_IDX_ONESHOT     4'h9
`define LDI_RST_SELECT      8'h00
`define LDI_RST_TIME        8'h44
`define LDI_RST_MAXINT      8'hff
`define LDI_RST_ONESHOT     8'h0f
`define LDI_RST_CMD         8'h00

// Enable filter timing on the device clock
`define LDI_EN_LOW_NS       60000
`define LDI_DEV_CLK_NS      32
`define LDI_EN_LOW_CYC      ((`LDI_EN_LOW_NS + `LDI_DEV_CLK_NS - 1) / `LDI_DEV_CLK_NS)

// Controller serial clock timing on pclk
`define LDI_PCLK_NS         50
`define LDI_SCL_HALF_NS     500
`define LDI_SCL_HALF_CYC    (`LDI_SCL_HALF_NS / `LDI_PCLK_NS)
`define LDI_SCL_HALF_MIN    16'h0004

// Controller APB register offsets and fields
`define LDI_OFS_CMD         12'h000
`define LDI_OFS_STATUS      12'h004
`define LDI_OFS_WDATA       12'h008
`define LDI_OFS_RDATA       12'h00c
`define LDI_OFS_DIV         12'h010
`define LDI_CMD_CNT_LSB     8
`define LDI_CMD_READ_BIT    12
`define LDI_MAX_BYTES       3'h4
`define LDI_STAT_BUSY_BIT   0
`define LDI_STAT_NACK_BIT   1

`endif

// ===== ldi_pkg.sv
package ldi_pkg;

  typedef enum logic [2:0] {D_IDLE, D_RX, D_RX_ACK, D_TX, D_TX_ACK} ldi_dstate_t;

  typedef enum logic [1:0] {K_ADDR, K_CMD, K_DATA} ldi_kind_t;

  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_RSTART, H_STOP} ldi_hstate_t;

  typedef enum logic [2:0] {S_ADDR_W, S_CMD, S_WDATA, S_ADDR_R, S_RDATA} ldi_stage_t;

endpackage : ldi_pkg

// ===== ldi_bus_if.sv
`timescale 1ns/1ps
interface ldi_bus_if;
  logic ctl_scl_o;
  logic ctl_scl_oe_n;
  logic ctl_sda_o;
  logic ctl_sda_oe_n;
  logic tgt_sda_o;
  logic tgt_sda_oe_n;
  logic scl;
  logic sda;

  // Wired-AND of open-drain drivers with pull-ups
  assign scl = ctl_scl_oe_n ? 1'b1 : ctl_scl_o;
  assign sda = (ctl_sda_oe_n ? 1'b1 : ctl_sda_o) & (tgt_sda_oe_n ? 1'b1 : tgt_sda_o);

  modport controller (output ctl_scl_o, output ctl_scl_oe_n, output ctl_sda_o, output ctl_sda_oe_n,
                      input scl, input sda);
  modport target (output tgt_sda_o, output tgt_sda_oe_n, input scl, input sda);
endinterface : ldi_bus_if

// ===== ldi_sync.sv
`timescale 1ns/1ps
module ldi_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // Idle bus and enabled device both read as high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '1;
      q    <= '1;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : ldi_sync

// ===== ldi_ctrl.sv
`timescale 1ns/1ps
`include "ldi_consts.svh"
module ldi_ctrl (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial bus
  ldi_bus_if.controller    bus
);
  logic                 sda_s;
  logic [7:0]           cmd_byte;
  logic [2:0]           cnt;
  logic                 rd_mode;
  logic [31:0]          wdata;
  logic [31:0]          rdata;
  logic [15:0]          half;
  logic [15:0]          tcnt;
  logic                 tick;
  logic                 nack;
  logic                 busy;
  logic                 go;
  logic                 wr_en;
  ldi_pkg::ldi_hstate_t state;
  ldi_pkg::ldi_stage_t  stage;
  logic [1:0]           sub;
  logic [3:0]           bitn;
  logic [7:0]           sh;
  logic [1:0]           idx;
  logic                 tx_stage;
  logic                 last_rd;
  logic [2:0]           cnt_rd;
  logic [2:0]           v_cnt;

  function automatic logic ldi_known(input logic [11:0] a);
    return (a == `LDI_OFS_CMD) || (a == `LDI_OFS_STATUS) || (a == `LDI_OFS_WDATA) ||
           (a == `LDI_OFS_RDATA) || (a == `LDI_OFS_DIV);
  endfunction : ldi_known

  ldi_sync #(.WIDTH(1)) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (bus.sda),
    .q     (sda_s)
  );

  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~ldi_known(paddr);
  assign wr_en    = psel & penable & pwrite;
  assign busy     = (state != ldi_pkg::H_IDLE);
  // A launch while busy is ignored rather than queued
  assign go       = wr_en && (paddr == `LDI_OFS_CMD) && !busy;
  assign v_cnt    = pwdata[`LDI_CMD_CNT_LSB +: 3];
  assign tx_stage = (stage != ldi_pkg::S_RDATA);
  assign cnt_rd   = (cnt == 3'h0) ? 3'h1 : cnt;
  assign last_rd  = ({1'b0, idx} == cnt_rd - 3'h1);
  assign tick     = (tcnt == 16'h0000);
  assign bus.ctl_scl_o = 1'b0;
  assign bus.ctl_sda_o = 1'b0;

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_byte <= 8'h00;
      cnt      <= 3'h0;
      rd_mode  <= 1'b0;
      wdata    <= 32'h0000_0000;
      half     <= 16'(`LDI_SCL_HALF_CYC);
    end else if (wr_en) begin
      if (go) begin
        cmd_byte <= pwdata[7:0];
        cnt      <= (v_cnt > `LDI_MAX_BYTES) ? `LDI_MAX_BYTES : v_cnt;
        rd_mode  <= pwdata[`LDI_CMD_READ_BIT];
      end
      if (paddr == `LDI_OFS_WDATA) begin
        wdata <= pwdata;
      end
      if (paddr == `LDI_OFS_DIV) begin
        half <= (pwdata[15:0] < `LDI_SCL_HALF_MIN) ? `LDI_SCL_HALF_MIN : pwdata[15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        `LDI_OFS_CMD:    prdata <= {19'h0_0000, rd_mode, 1'b0, cnt, cmd_byte};
        `LDI_OFS_STATUS: prdata <= {30'h0000_0000, nack, busy};
        `LDI_OFS_WDATA:  prdata <= wdata;
        `LDI_OFS_RDATA:  prdata <= rdata;
        `LDI_OFS_DIV:    prdata <= {16'h0000, half};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Half-period timebase for the serial clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt <= 16'h0000;
    end else if (tick) begin
      tcnt <= half - 16'h0001;
    end else begin
      tcnt <= tcnt - 16'h0001;
    end
  end

  // Bus sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state            <= ldi_pkg::H_IDLE;
      stage            <= ldi_pkg::S_ADDR_W;
      sub              <= 2'h0;
      bitn             <= 4'h0;
      sh               <= 8'h00;
      idx              <= 2'h0;
      nack             <= 1'b0;
      rdata            <= 32'h0000_0000;
      bus.ctl_scl_oe_n <= 1'b1;
      bus.ctl_sda_oe_n <= 1'b1;
    end else if (go) begin
      state <= ldi_pkg::H_START;
      stage <= ldi_pkg::S_ADDR_W;
      sub   <= 2'h0;
      nack  <= 1'b0;
      sh    <= {`LDI_DEV_ADDR, 1'b0};
    end else if (tick) begin
      case (state)
        ldi_pkg::H_IDLE: begin
          bus.ctl_scl_oe_n <= 1'b1;
          bus.ctl_sda_oe_n <= 1'b1;
        end
        ldi_pkg::H_START: begin
          sub <= sub + 2'h1;
          if (sub == 2'h0) begin
            bus.ctl_sda_oe_n <= 1'b0;
          end else begin
            bus.ctl_scl_oe_n <= 1'b0;
            state <= ldi_pkg::H_BIT;
            bitn  <= 4'h0;
            sub   <= 2'h0;
          end
        end
        ldi_pkg::H_BIT: begin
          if (sub == 2'h0) begin
            sub <= 2'h1;
            if (bitn != 4'h8) begin
              bus.ctl_sda_oe_n <= tx_stage ? sh[7] : 1'b1;
            end else begin
              bus.ctl_sda_oe_n <= tx_stage ? 1'b1 : last_rd;
            end
          end else if (sub == 2'h1) begin
            bus.ctl_scl_oe_n <= 1'b1;
            sub <= 2'h2;
          end else begin
            bus.ctl_scl_oe_n <= 1'b0;
            sub <= 2'h0;
            if (bitn != 4'h8) begin
              sh   <= {sh[6:0], sda_s};
              bitn <= bitn + 4'h1;
            end else begin
              bitn <= 4'h0;
              if (tx_stage && sda_s) begin
                nack  <= 1'b1;
                state <= ldi_pkg::H_STOP;
              end else begin
                case (stage)
                  ldi_pkg::S_ADDR_W: begin
                    stage <= ldi_pkg::S_CMD;
                    sh    <= cmd_byte;
                  end
                  ldi_pkg::S_CMD: begin
                    if (rd_mode) begin
                      state <= ldi_pkg::H_RSTART;
                    end else if (cnt == 3'h0) begin
                      state <= ldi_pkg::H_STOP;
                    end else begin
                      stage <= ldi_pkg::S_WDATA;
                      idx   <= 2'h0;
                      sh    <= wdata[7:0];
                    end
                  end
                  ldi_pkg::S_WDATA: begin
                    if ({1'b0, idx} == cnt - 3'h1) begin
                      state <= ldi_pkg::H_STOP;
                    end else begin
                      idx <= idx + 2'h1;
                      sh  <= wdata[{idx + 2'h1, 3'b000} +: 8];
                    end
                  end
                  ldi_pkg::S_ADDR_R: begin
                    stage <= ldi_pkg::S_RDATA;
                    idx   <= 2'h0;
                  end
                  ldi_pkg::S_RDATA: begin
                    rdata[{idx, 3'b000} +: 8] <= sh;
                    if (last_rd) begin
                      state <= ldi_pkg::H_STOP;
                    end else begin
                      idx <= idx + 2'h1;
                    end
                  end
                  default: begin
                    state <= ldi_pkg::H_STOP;
                  end
                endcase
              end
            end
          end
        end
        ldi_pkg::H_RSTART: begin
          sub <= sub + 2'h1;
          case (sub)
            2'h0: bus.ctl_sda_oe_n <= 1'b1;
            2'h1: bus.ctl_scl_oe_n <= 1'b1;
            2'h2: bus.ctl_sda_oe_n <= 1'b0;
            default: begin
              bus.ctl_scl_oe_n <= 1'b0;
              state <= ldi_pkg::H_BIT;
              stage <= ldi_pkg::S_ADDR_R;
              sh    <= {`LDI_DEV_ADDR, 1'b1};
              bitn  <= 4'h0;
              sub   <= 2'h0;
            end
          endcase
        end
        ldi_pkg::H_STOP: begin
          sub <= sub + 2'h1;
          case (sub)
            2'h0: bus.ctl_sda_oe_n <= 1'b0;
            2'h1: bus.ctl_scl_oe_n <= 1'b1;
            default: begin
              bus.ctl_sda_oe_n <= 1'b1;
              state <= ldi_pkg::H_IDLE;
              sub   <= 2'h0;
            end
          endcase
        end
        default: begin
          state <= ldi_pkg::H_IDLE;
        end
      endcase
    end
  end
endmodule : ldi_ctrl

// ===== ldi_assertions.sv
`timescale 1ns/1ps
module ldi_assertions (
  // Device side
  input wire logic       dev_clk,
  input wire logic       por_n,
  input wire logic       en,
  input wire logic       reg_wr,
  input wire logic [3:0] reg_wr_index,
  input wire logic       init_pulse,
  input wire logic       rd_strobe,
  input wire logic       bus_active,
  input wire logic       osc_run,
  // Serial lines
  input wire logic       scl,
  input wire logic       sda,
  input wire logic       tgt_sda_oe_n
);
  default clocking @(posedge dev_clk); endclocking
  default disable iff (!por_n);

  property p_wr_range; reg_wr |-> reg_wr_index < 4'ha; endproperty
  a_wr_range: assert property (p_wr_range) else $error("store to unmapped index");
  property p_init_excl; init_pulse |-> !reg_wr; endproperty
  a_init_excl: assert property (p_init_excl) else $error("init write also stored");
  property p_wr_pulse; reg_wr |=> !reg_wr; endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("store pulse too long");
  property p_rd_pulse; rd_strobe |-> bus_active ##1 !rd_strobe; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read load outside transfer");
  property p_tgt_idle; !bus_active |-> tgt_sda_oe_n; endproperty
  a_tgt_idle: assert property (p_tgt_idle) else $error("target drives data while idle");
  // Target may only move data while the clock is low, or it would fake START/STOP
  property p_tgt_scl_low; $changed(tgt_sda_oe_n) |-> !scl; endproperty
  a_tgt_scl_low: assert property (p_tgt_scl_low) else $error("target data changed with clock high");
  property p_osc_off; $fell(osc_run) |-> !$past(en, 3); endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator stopped while enabled");
  property p_start; $rose(bus_active) |-> !sda; endproperty
  a_start: assert property (p_start) else $error("engine woke without start");
endmodule : ldi_assertions

// ===== tb_led_driver_i2c_register_access.sv
`timescale 1ns/1ps
module tb_led_driver_i2c_register_access;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, perr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, st, rd;
  logic        dev_clk = 0, por_n = 0, en = 1, pready, pslverr;
  logic        reg_wr, init_pulse, rd_strobe, bus_active, osc_run;
  logic [3:0]  reg_wr_index;
  logic [7:0]  reg_wr_data, cmd_ptr;
  int          n_errors = 0, check_count = 0, n_init = 0;

  always #25 pclk = ~pclk;
  // Odd offset keeps the link clock out of phase with pclk
  initial #7 forever #16 dev_clk = ~dev_clk;

  ldi_bus_if bus ();
  ldi_ctrl u_ldi_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus.controller));
  // Short enable filter keeps the shutdown case brief
  ldi_target #(.EN_LOW_CYC(20)) u_ldi_target (.dev_clk(dev_clk), .por_n(por_n), .en(en), .bus(bus.target),
    .reg_wr(reg_wr), .reg_wr_index(reg_wr_index), .reg_wr_data(reg_wr_data), .init_pulse(init_pulse),
    .rd_strobe(rd_strobe), .command_pointer(cmd_ptr), .bus_active(bus_active), .osc_run(osc_run));
  ldi_assertions u_ldi_assertions (.dev_clk(dev_clk), .por_n(por_n), .en(en), .reg_wr(reg_wr),
    .reg_wr_index(reg_wr_index), .init_pulse(init_pulse), .rd_strobe(rd_strobe), .bus_active(bus_active),
    .osc_run(osc_run), .scl(bus.scl), .sda(bus.sda), .tgt_sda_oe_n(bus.tgt_sda_oe_n));

  always @(posedge dev_clk) if (init_pulse === 1'b1) n_init <= n_init + 1;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++i < 64);
    if (i >= 64) n_errors++;
    r = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Launch one serial transfer and wait until the controller is idle again
  task automatic xfer(input logic [31:0] c, input logic [31:0] wd);
    int i;
    i = 0;
    apb(1'b1, 12'h008, wd, rd);
    apb(1'b1, 12'h000, c, rd);
    do apb(1'b0, 12'h004, 32'h0, st); while (st[0] !== 1'b0 && ++i < 3000);
    if (i >= 3000) n_errors++;
    apb(1'b0, 12'h00c, 32'h0, rd);
  endtask : xfer

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out

  initial begin
    #3000000;
    n_errors++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    repeat (5) @(posedge pclk);
    xfer(32'h00001413, 32'h0);
    chk("rdata", 32'h44444444, rd);
    xfer(32'h00001218, 32'h0);
    chk("rdata", 32'h00000fff, {16'h0, rd[15:0]});
    xfer(32'h00000103, 32'h55);
    chk("status", 32'h0, {30'h0, st[1:0]});
    chk("wr_data", 32'h00000355, {20'h0, reg_wr_index, reg_wr_data});
    // Command bytes in every launch keep the reserved top bits at zero
    xfer(32'h0000000b, 32'h0);
    chk("pointer", 32'h0000000b, {24'h0, cmd_ptr});
    xfer(32'h00000419, 32'h44332211);
    chk("init", 32'h1, n_init);
    xfer(32'h00001219, 32'h0);
    chk("rdata", 32'h00000011, {16'h0, rd[15:0]});
    xfer(32'h00001410, 32'h0);
    chk("rdata", 32'h55004433, rd);
    xfer(32'h00000302, 32'h00ccbbaa);
    xfer(32'h00001312, 32'h0);
    chk("rdata", 32'h004455cc, {8'h0, rd[23:0]});
    xfer(32'h0000010c, 32'h77);
    chk("status", 32'h0, {30'h0, st[1:0]});
    xfer(32'h00001410, 32'h0);
    chk("rdata", 32'h55cc4433, rd);
    chk("init", 32'h1, n_init);
    @(posedge dev_clk);
    en <= 1'b0;
    repeat (40) @(posedge dev_clk);
    chk("osc_run", 32'h0, {31'h0, osc_run});
    en <= 1'b1;
    repeat (10) @(posedge dev_clk);
    chk("osc_run", 32'h1, {31'h0, osc_run});
    chk("pointer", 32'h0, {24'h0, cmd_ptr});
    xfer(32'h00001410, 32'h0);
    chk("rdata", 32'h44000000, rd);
    apb(1'b0, 12'h020, 32'h0, rd);
    chk("pslverr", 32'h1, {31'h0, perr});
    close_out();
  end
endmodule : tb_led_driver_i2c_register_access
